// *** hdl/svppm_pkg.sv ***
package svppm_pkg;
  // ----------------------------------------------------------------------
  // Source voltage format
  // ----------------------------------------------------------------------
  localparam int VSRC_BITS = 11;
  localparam int VSRC_REG_BITS = 16;
  localparam int VSRC_PAD_BITS = 5;
  localparam real FULL_SCALE_VOLTS = 23.9883;
  localparam int VSRC_SCALE_DIV = 4094;
  localparam int FULL_SCALE_WATTS_CODE = 65535;
  // ----------------------------------------------------------------------
  // Sense voltage and power ratio
  // ----------------------------------------------------------------------
  localparam int VSNS_BITS = 11;
  localparam int VSNS_MAG_BITS = 10;
  localparam int PROD_BITS = 21;
  localparam int PRATIO_BITS = 16;
  localparam int PRATIO_LSB = 5;
  // ----------------------------------------------------------------------
  // Peak detector
  // ----------------------------------------------------------------------
  localparam int SEL_BITS = 4;
  localparam int SEL_COUNT = 16;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_BITS = 15;
  localparam int DUR_BITS = 13;
  localparam int FILT_BITS = 16;
  localparam int HYST_BITS = 11;
  localparam logic [VSRC_BITS-1:0] VSRC_ZERO = 11'h000;
endpackage

// *** hdl/svppm_peak.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Peak detector with threshold, minimum duration and release filter
// --------------------------------------------------------------------------
module svppm_peak #(
  parameter int FILT_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [svppm_pkg::VSNS_MAG_BITS-1:0] mag,
  input wire logic [svppm_pkg::VSNS_MAG_BITS-1:0] thresh,
  input wire logic [svppm_pkg::DUR_BITS-1:0] dur_ms,
  output logic peak
);
  logic [svppm_pkg::TICK_BITS-1:0] tick_q, tick_d;
  logic [svppm_pkg::DUR_BITS-1:0] ms_q, ms_d;
  logic [svppm_pkg::FILT_BITS-1:0] filt_q, filt_d;
  logic run_q, run_d, peak_q, peak_d;
  logic over;

  always_comb begin
    over = mag > thresh;
    tick_d = tick_q;
    ms_d = ms_q;
    filt_d = filt_q;
    run_d = run_q;
    peak_d = peak_q;
    if (over) begin
      filt_d = '0;
      run_d = 1'b1;
    end else if (run_q) begin
      if (filt_q >= svppm_pkg::FILT_BITS'(FILT_CYCLES)) begin
        run_d = 1'b0;
        peak_d = 1'b0;
      end else begin
        filt_d = filt_q + 1'b1;
      end
    end
    if (!run_d) begin
      tick_d = '0;
      ms_d = '0;
      filt_d = '0;
    end else if (!peak_q) begin
      if (tick_q == svppm_pkg::TICK_BITS'(svppm_pkg::TICK_CYCLES - 1)) begin
        tick_d = '0;
        ms_d = ms_q + 1'b1;
      end else begin
        tick_d = tick_q + 1'b1;
      end
      if (ms_q >= dur_ms && over) begin
        peak_d = 1'b1;
      end
    end
    if (peak_q && !over) begin
      peak_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
      ms_q <= '0;
      filt_q <= '0;
      run_q <= 1'b0;
      peak_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      ms_q <= ms_d;
      filt_q <= filt_d;
      run_q <= run_d;
      peak_q <= peak_d;
    end
  end

  assign peak = peak_q;
endmodule // svppm_peak

// *** hdl/svppm_monitor.sv ***
`timescale 1ns/1ps
module svppm_monitor #(
  parameter int FILT_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic vsrc_valid,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_code,
  input wire logic vsns_valid,
  input wire logic signed [svppm_pkg::VSNS_BITS-1:0] vsns_code,
  input wire logic signed [svppm_pkg::VSNS_BITS-1:0] vsns_inst,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_high,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_low,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_crit,
  input wire logic [svppm_pkg::HYST_BITS-1:0] vsrc_hyst,
  input wire logic warn_enable,
  input wire logic comparator_mode,
  input wire logic warn_mask_all,
  input wire logic warn_clear,
  input wire logic [svppm_pkg::SEL_BITS-1:0] spike_level_strap,
  input wire logic [svppm_pkg::SEL_BITS-1:0] spike_time_strap,
  input wire logic host_sel_write,
  input wire logic [svppm_pkg::SEL_BITS-1:0] host_level_sel,
  input wire logic [svppm_pkg::SEL_BITS-1:0] host_time_sel,
  output logic [svppm_pkg::VSRC_REG_BITS-1:0] vsrc_reg,
  output logic [svppm_pkg::PRATIO_BITS-1:0] power_ratio,
  output logic high_status,
  output logic low_status,
  output logic spike_status,
  output logic warn_out_n,
  output logic critical_out_n,
  output logic [svppm_pkg::SEL_BITS-1:0] level_sel,
  output logic [svppm_pkg::SEL_BITS-1:0] time_sel
);
  // ------------------------------------------------------------------------
  // Strap capture after reset, host override
  // ------------------------------------------------------------------------
  logic [svppm_pkg::SEL_BITS-1:0] ls_s1_q, ls_s2_q, ls_s3_q, ts_s1_q;
  logic [svppm_pkg::SEL_BITS-1:0] ts_s2_q, ts_s3_q;
  logic [svppm_pkg::SEL_BITS-1:0] lsel_q, lsel_d, tsel_q, tsel_d;
  logic [1:0] boot_q, boot_d;
  logic host_q, host_d;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ls_s1_q <= '0;
      ls_s2_q <= '0;
      ls_s3_q <= '0;
      ts_s1_q <= '0;
      ts_s2_q <= '0;
      ts_s3_q <= '0;
    end else begin
      ls_s1_q <= spike_level_strap;
      ls_s2_q <= ls_s1_q;
      ls_s3_q <= ls_s2_q;
      ts_s1_q <= spike_time_strap;
      ts_s2_q <= ts_s1_q;
      ts_s3_q <= ts_s2_q;
    end
  end

  always_comb begin
    boot_d = boot_q;
    lsel_d = lsel_q;
    tsel_d = tsel_q;
    host_d = host_q;
    if (host_sel_write) begin
      lsel_d = host_level_sel;
      tsel_d = host_time_sel;
      host_d = 1'b1;
    end else if (!host_q && boot_q != 2'h3) begin
      // Straps are taken only once the synchroniser has settled.
      if (ls_s2_q == ls_s3_q && ts_s2_q == ts_s3_q) begin
        boot_d = boot_q + 2'h1;
        lsel_d = ls_s3_q;
        tsel_d = ts_s3_q;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_q <= '0;
      lsel_q <= '0;
      tsel_q <= '0;
      host_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      lsel_q <= lsel_d;
      tsel_q <= tsel_d;
      host_q <= host_d;
    end
  end

  // ------------------------------------------------------------------------
  // Selection tables
  // ------------------------------------------------------------------------
  // Threshold in sense codes: 10 mV to 85 mV on an 80 mV, 1023 code span.
  // Levels above full scale saturate, so they can never trip.
  logic [svppm_pkg::VSNS_MAG_BITS-1:0] thr_code;
  logic [svppm_pkg::DUR_BITS-1:0] dur_ms;

  always_comb begin
    unique case (lsel_q)
      4'h0: thr_code = 10'h080;
      4'h1: thr_code = 10'h0C0;
      4'h2: thr_code = 10'h100;
      4'h3: thr_code = 10'h140;
      4'h4: thr_code = 10'h180;
      4'h5: thr_code = 10'h1C0;
      4'h6: thr_code = 10'h200;
      4'h7: thr_code = 10'h240;
      4'h8: thr_code = 10'h280;
      4'h9: thr_code = 10'h2C0;
      4'hA: thr_code = 10'h300;
      4'hB: thr_code = 10'h340;
      4'hC: thr_code = 10'h380;
      4'hD: thr_code = 10'h3C0;
      4'hE: thr_code = 10'h3FF;
      4'hF: thr_code = 10'h3FF;
    endcase
    unique case (tsel_q)
      4'h0: dur_ms = 13'h0001;
      4'h1: dur_ms = 13'h0005;
      4'h2: dur_ms = 13'h001A;
      4'h3: dur_ms = 13'h0033;
      4'h4: dur_ms = 13'h004D;
      4'h5: dur_ms = 13'h0066;
      4'h6: dur_ms = 13'h0080;
      4'h7: dur_ms = 13'h0100;
      4'h8: dur_ms = 13'h0180;
      4'h9: dur_ms = 13'h0200;
      4'hA: dur_ms = 13'h0300;
      4'hB: dur_ms = 13'h0400;
      4'hC: dur_ms = 13'h0600;
      4'hD: dur_ms = 13'h0800;
      4'hE: dur_ms = 13'h0C00;
      4'hF: dur_ms = 13'h1000;
    endcase
  end

  // ------------------------------------------------------------------------
  // Peak detector on instantaneous magnitude
  // ------------------------------------------------------------------------
  logic [svppm_pkg::VSNS_MAG_BITS-1:0] inst_mag;
  logic peak;

  always_comb begin
    if (vsns_inst[svppm_pkg::VSNS_BITS-1]) begin
      inst_mag = svppm_pkg::VSNS_MAG_BITS'(-vsns_inst);
    end else begin
      inst_mag = vsns_inst[svppm_pkg::VSNS_MAG_BITS-1:0];
    end
  end

  svppm_peak #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_peak (
    .sys_clk(sys_clk),
    .rst(rst),
    .mag(inst_mag),
    .thresh(thr_code),
    .dur_ms(dur_ms),
    .peak(peak)
  );

  // ------------------------------------------------------------------------
  // Source voltage, limits and power ratio
  // ------------------------------------------------------------------------
  logic [svppm_pkg::VSRC_BITS-1:0] vsrc_q, vsrc_d;
  logic [svppm_pkg::VSNS_MAG_BITS-1:0] smag_q, smag_d;
  logic [svppm_pkg::PRATIO_BITS-1:0] pr_q, pr_d;
  logic hi_q, hi_d, lo_q, lo_d, crit_q, crit_d, warn_q, warn_d;
  logic [svppm_pkg::PROD_BITS-1:0] prod;
  logic [svppm_pkg::VSRC_BITS:0] release_lvl;
  logic new_v, new_s;

  always_comb begin
    new_v = vsrc_valid;
    new_s = vsns_valid;
    vsrc_d = new_v ? vsrc_code : vsrc_q;
    smag_d = smag_q;
    if (new_s) begin
      if (vsns_code[svppm_pkg::VSNS_BITS-1]) begin
        smag_d = svppm_pkg::VSNS_MAG_BITS'(-vsns_code);
      end else begin
        smag_d = vsns_code[svppm_pkg::VSNS_MAG_BITS-1:0];
      end
    end
    prod = svppm_pkg::PROD_BITS'(smag_d) * svppm_pkg::PROD_BITS'(vsrc_d);
    // The shifted product keeps the top 16 bits; full codes map to 65440.
    pr_d = pr_q;
    if (new_v || new_s) begin
      pr_d = prod[svppm_pkg::PRATIO_LSB +: svppm_pkg::PRATIO_BITS];
    end
    release_lvl = {1'b0, vsrc_high} - {1'b0, vsrc_hyst};
    hi_d = hi_q;
    lo_d = lo_q;
    if (comparator_mode) begin
      if (vsrc_d >= vsrc_high) begin
        hi_d = 1'b1;
      end else if (release_lvl[svppm_pkg::VSRC_BITS] ||
                   {1'b0, vsrc_d} < release_lvl) begin
        hi_d = 1'b0;
      end
    end else begin
      if (warn_clear) begin
        hi_d = 1'b0;
      end
      if (new_v && vsrc_d >= vsrc_high) begin
        hi_d = 1'b1;
      end
    end
    if (warn_clear) begin
      lo_d = 1'b0;
    end
    if (new_v && vsrc_d < vsrc_low) begin
      lo_d = 1'b1;
    end
    crit_d = vsrc_d >= vsrc_crit;
    if (comparator_mode) begin
      warn_d = warn_enable && (hi_d || lo_d || peak);
    end else begin
      warn_d = warn_enable && !warn_mask_all && (hi_d || lo_d);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vsrc_q <= svppm_pkg::VSRC_ZERO;
      smag_q <= '0;
      pr_q <= '0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
      crit_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      vsrc_q <= vsrc_d;
      smag_q <= smag_d;
      pr_q <= pr_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      crit_q <= crit_d;
      warn_q <= warn_d;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------------
  logic [svppm_pkg::VSRC_REG_BITS-1:0] vreg_q;
  logic spike_q, crit_n_q, warn_n_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vreg_q <= '0;
      spike_q <= 1'b0;
      crit_n_q <= 1'b1;
      warn_n_q <= 1'b1;
    end else begin
      vreg_q <= {vsrc_d, {svppm_pkg::VSRC_PAD_BITS{1'b0}}};
      spike_q <= peak;
      crit_n_q <= !(crit_d || peak);
      warn_n_q <= !warn_d;
    end
  end

  assign vsrc_reg = vreg_q;
  assign power_ratio = pr_q;
  assign high_status = hi_q;
  assign low_status = lo_q;
  assign spike_status = spike_q;
  assign warn_out_n = warn_n_q;
  assign critical_out_n = crit_n_q;
  assign level_sel = lsel_q;
  assign time_sel = tsel_q;
endmodule // svppm_monitor

// *** tb/svppm_chk_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker for the source monitor
// ----------------------------------------------------------------------
module svppm_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic vsrc_valid,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_code,
  input wire logic vsns_valid,
  input wire logic signed [svppm_pkg::VSNS_BITS-1:0] vsns_inst,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_high,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_low,
  input wire logic [svppm_pkg::VSRC_BITS-1:0] vsrc_crit,
  input wire logic host_sel_write,
  input wire logic [svppm_pkg::SEL_BITS-1:0] host_level_sel,
  input wire logic [svppm_pkg::SEL_BITS-1:0] host_time_sel,
  input wire logic [svppm_pkg::VSRC_REG_BITS-1:0] vsrc_reg,
  input wire logic [svppm_pkg::PRATIO_BITS-1:0] power_ratio,
  input wire logic high_status,
  input wire logic low_status,
  input wire logic spike_status,
  input wire logic critical_out_n,
  input wire logic [svppm_pkg::SEL_BITS-1:0] level_sel,
  input wire logic [svppm_pkg::SEL_BITS-1:0] time_sel
);
  logic [9:0] mag;
  logic [9:0] thr;
  logic over;
  // The two top indices saturate, so the threshold never wraps.
  always_comb begin
    mag = vsns_inst[10] ? 10'(-vsns_inst) : vsns_inst[9:0];
    thr = (level_sel > 4'hD) ? 10'h3FF : 10'(10'h080 + level_sel * 10'h040);
    over = mag > thr;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_under;
    (!over)[*4];
  endsequence
  property p_pad;
    vsrc_reg[4:0] == 5'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits set");
  property p_reg;
    vsrc_valid |=> vsrc_reg == {$past(vsrc_code), 5'h00};
  endproperty
  a_reg: assert property (p_reg) else $error("stored code");
  property p_crit;
    vsrc_valid && vsrc_code >= vsrc_crit |=> !critical_out_n;
  endproperty
  a_crit: assert property (p_crit) else $error("no critical");
  property p_high;
    vsrc_valid && vsrc_code >= vsrc_high |=> high_status;
  endproperty
  a_high: assert property (p_high) else $error("no high");
  property p_low;
    vsrc_valid && vsrc_code < vsrc_low |=> low_status;
  endproperty
  a_low: assert property (p_low) else $error("no low");
  property p_hold;
    !(vsrc_valid || vsns_valid) |=> $stable(power_ratio);
  endproperty
  a_hold: assert property (p_hold) else $error("ratio moved");
  property p_spk;
    spike_status |-> !critical_out_n;
  endproperty
  a_spk: assert property (p_spk) else $error("spike no crit");
  property p_rel;
    s_under |-> !spike_status;
  endproperty
  a_rel: assert property (p_rel) else $error("spike held");
  property p_rise;
    $rose(spike_status) |-> $past(over) || $past(over, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("spike no cause");
  property p_sel;
    host_sel_write |=> level_sel == $past(host_level_sel) &&
      time_sel == $past(host_time_sel);
  endproperty
  a_sel: assert property (p_sel) else $error("host sel lost");
endmodule // svppm_chk

// *** tb/svppm_front_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Sense front end: instantaneous current sample
// ----------------------------------------------------------------------
module svppm_front_model (
  input wire logic sys_clk,
  input wire logic [9:0] spike_mag,
  input wire logic spike_neg,
  output logic [10:0] vsns_inst
);
  logic [3:0] noise_q = 4'h0;
  // Quiet current wanders in both signs so a stuck input shows up.
  always @(posedge sys_clk) noise_q <= noise_q + 4'h3;
  always_comb begin
    if (spike_mag != 10'h000) begin
      vsns_inst = spike_neg ? -{1'b0, spike_mag} : {1'b0, spike_mag};
    end else begin
      vsns_inst = noise_q[0] ? -{7'h00, noise_q} : {7'h00, noise_q};
    end
  end
endmodule // svppm_front_model

// *** tb/svppm_monitor_tb.sv ***
`timescale 1ns/1ps
module svppm_monitor_tb;
  logic sys_clk = 1'b0, rst = 1'b1, vsrc_valid = 1'b0, vsns_valid = 1'b0;
  logic [10:0] vsrc_code = 11'h000, vsns_code = 11'h000, vsns_inst;
  logic [10:0] vsrc_high = 11'h500, vsrc_low = 11'h100;
  logic [10:0] vsrc_crit = 11'h600, vsrc_hyst = 11'h010;
  logic warn_enable = 1'b1, comparator_mode = 1'b0, warn_mask_all = 1'b0;
  logic warn_clear = 1'b0, host_sel_write = 1'b0, spike_neg = 1'b1;
  logic [3:0] spike_level_strap = 4'h2, spike_time_strap = 4'h0;
  logic [3:0] host_level_sel = 4'h0, host_time_sel = 4'h0;
  logic [3:0] level_sel, time_sel;
  logic [9:0] spike_mag = 10'h000, mag_m = 10'h000;
  logic [15:0] vsrc_reg, power_ratio;
  logic high_status, low_status, spike_status, warn_out_n, critical_out_n;
  logic [10:0] src_m = 11'h000;
  logic [31:0] exp_q[$];
  logic seen;
  int n_fail = 0;
  int tests_run = 0;
  svppm_monitor #(.FILT_CYCLES(4)) u_svppm_monitor (.*);
  svppm_front_model u_svppm_front_model (.*);
  always #25 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic upd(input logic sv, input logic nv, input logic [10:0] c,
                     input logic [10:0] s);
    logic [20:0] p;
    @(posedge sys_clk);
    vsrc_valid <= sv;
    vsns_valid <= nv;
    vsrc_code <= c;
    vsns_code <= s;
    if (sv) src_m = c;
    if (nv) mag_m = s[10] ? 10'(-s) : s[9:0];
    p = mag_m * src_m;
    exp_q.push_back({src_m, 5'h00, p[20:5]});
  endtask
  // Strobes drop after the first edge, so a caller may raise one on return.
  task automatic wait_n(input int n);
    @(posedge sys_clk);
    vsrc_valid <= 1'b0;
    vsns_valid <= 1'b0;
    host_sel_write <= 1'b0;
    warn_clear <= 1'b0;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Results show one edge after their valid, so look at the next low phase.
  always begin
    @(posedge sys_clk);
    seen = vsrc_valid | vsns_valid;
    @(negedge sys_clk);
    if (seen && exp_q.size() > 0) begin
      check(exp_q.pop_front(), {vsrc_reg, power_ratio});
    end
  end
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(20));
    wait_n(8);
    rst <= 1'b0;
    wait_n(12);
    check(32'(level_sel), 32'h2);
    check(32'(time_sel), 32'h0);
    spike_level_strap <= 4'h9;
    for (int i = 0; i < 40; i++) begin
      upd(i % 3 != 1, i % 3 != 0, 11'($urandom_range(256, 1279)),
          11'($urandom));
    end
    upd(1'b1, 1'b0, 11'h700, 11'h000);
    upd(1'b1, 1'b0, 11'h050, 11'h000);
    upd(1'b1, 1'b0, 11'h300, 11'h000);
    wait_n(2);
    warn_clear <= 1'b1;
    wait_n(3);
    check(32'(warn_out_n), 32'h1);
    check(32'(level_sel), 32'h2);
    spike_mag <= 10'h180;
    wait_n(20050);
    check(32'(spike_status), 32'h1);
    check(32'(critical_out_n), 32'h0);
    check(32'(warn_out_n), 32'h1);
    comparator_mode <= 1'b1;
    wait_n(3);
    check(32'(warn_out_n), 32'h0);
    spike_mag <= 10'h000;
    wait_n(2);
    spike_mag <= 10'h180;
    wait_n(6);
    check(32'(spike_status), 32'h1);
    spike_mag <= 10'h000;
    wait_n(8);
    check({31'h0, spike_status}, 32'h0);
    check(32'(critical_out_n), 32'h1);
    upd(1'b1, 1'b0, 11'h500, 11'h000);
    upd(1'b1, 1'b0, 11'h4F8, 11'h000);
    wait_n(2);
    check(32'(high_status), 32'h1);
    check(32'(warn_out_n), 32'h0);
    upd(1'b1, 1'b0, 11'h4E0, 11'h000);
    wait_n(2);
    check(32'(high_status), 32'h0);
    check(32'(warn_out_n), 32'h1);
    host_sel_write <= 1'b1;
    host_level_sel <= 4'hF;
    wait_n(3);
    check(32'(level_sel), 32'hF);
    spike_neg <= 1'b0;
    spike_mag <= 10'h300;
    wait_n(20100);
    check(32'(spike_status), 32'h0);
    host_sel_write <= 1'b1;
    host_level_sel <= 4'h0;
    wait_n(20060);
    check(32'(spike_status), 32'h1);
    spike_mag <= 10'h000;
    wait_n(8);
    summarize();
  end
endmodule // svppm_monitor_tb
bind svppm_monitor svppm_chk u_chk (.*);
